// >>> src/ctg_defines.vh
// constants shared by the conditional tracking gate files
`ifndef CTG_DEFINES_VH
`define CTG_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define CTG_OFS_CTRL      6'h00
`define CTG_OFS_STATUS    6'h04
`define CTG_OFS_CMD       6'h08
`define CTG_OFS_INPUTS    6'h0c
`define CTG_OFS_OUTPUTS   6'h10
`define CTG_OFS_INMAP     6'h14
`define CTG_OFS_OUTMAP    6'h18
`define CTG_OFS_SELECT    6'h1c
`define CTG_OFS_POSCNT    6'h20

// ****************************************
// field positions and reset values
// ****************************************
`define CTG_CTRL_EXT_BIT  0
`define CTG_CTRL_ECLR_BIT 1
`define CTG_RST_MODE      2'h0
`define CTG_RST_EXT       1'h0
`define CTG_RST_OUT       16'h0000
`define CTG_BASE_IO       4

// ****************************************
// characters and keywords
// ****************************************
`define CTG_CH_COMMA      8'h2c
`define CTG_CH_SPACE      8'h20
`define CTG_CH_CR         8'h0d
`define CTG_CH_LF         8'h0a
`define CTG_CH_SEMI       8'h3b
`define CTG_CH_ZERO       8'h30
`define CTG_KW_COND       32'h50534f43
`define CTG_KW_DIST       32'h50534f44
`define CTG_KW_FIRE       32'h50534f46
`define CTG_KW_BMAP       32'h50534f4d
`define CTG_KW_PULSE      32'h50534f50
`define CTG_KW_RTIME      32'h50534f52
`define CTG_KW_IO         32'h50534f54

`endif

// >>> src/ctg_sync.v
// two-stage synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
module ctg_sync
#(
	parameter W = 8
)
(
	// clock and reset
	input  wire         clk,
	input  wire         nrst,
	// levels
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);

	reg [W-1:0] meta_reg;

	// first stage is read only by the second
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			meta_reg <= {W{1'b0}};
			q        <= {W{1'b0}};
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule // ctg_sync

// >>> src/ctg_cond.v
// tracking-enable condition from mode, configuration and input levels
`timescale 1ns/10ps
module ctg_cond
(
	// configuration
	input  wire [1:0] mode,
	input  wire [2:0] sel,
	input  wire       lvl,
	input  wire [7:0] in_care,
	input  wire [7:0] in_val,
	input  wire       ext,
	// levels
	input  wire [7:0] ins,
	output reg        cond
);

	reg [7:0] ins_eff;
	reg [7:0] care_eff;

	always @*
	begin
		// absent extension inputs read as pulled up; modes 0 and 3 never compare them
		ins_eff  = ext ? ins : {4'hf, ins[3:0]};
		care_eff = ext ? in_care : {4'h0, in_care[3:0]};
		case (mode)
			2'h0: cond = 1'b1;
			2'h1: cond = (ins_eff[sel] == lvl);
			2'h2: cond = (ins_eff[sel] == lvl);
			2'h3: cond = (((ins_eff ^ in_val) & care_eff) == 8'h00);
			default: cond = 1'b1;
		endcase
	end

endmodule // ctg_cond

// >>> src/ctg_gate.v
// conditional tracking gate: command parser, condition, outputs, bus slave
//
// The implementer's own choices: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`include "ctg_defines.vh"
module ctg_gate
#(
	parameter CW = 32
)
(
	// clock and reset
	input  wire          CLOCK,
	input  wire          NRST,
	// avalon-mm slave
	input  wire [5:0]    AVS_ADDRESS,
	input  wire          AVS_READ,
	input  wire          AVS_WRITE,
	input  wire [31:0]   AVS_WRITEDATA,
	output reg  [31:0]   AVS_READDATA,
	output reg           AVS_WAITREQUEST,
	// controller ribbon port
	input  wire [7:0]    CMD_DATA,
	input  wire          CMD_STROBE,
	// general inputs and position steps
	input  wire [7:0]    GEN_IN,
	input  wire          POS_STEP,
	// general outputs and tracking
	output reg  [15:0]   GEN_OUT,
	output reg           TRACK_EN
);

	// ****************************************
	// parser states
	// ****************************************
	localparam ST_KW   = 2'h0;
	localparam ST_ARGS = 2'h1;
	localparam ST_SKIP = 2'h2;

	localparam G_NONE  = 3'h0;
	localparam G_COND  = 3'h1;

	// ****************************************
	// functions
	// ****************************************
	function [7:0] fold;
		input [7:0] c;
		begin
			if (c >= 8'h61 && c <= 8'h7a)
				fold = c - 8'h20;
			else
				fold = c;
		end
	endfunction

	function is_term;
		input [7:0] c;
		begin
			is_term = (c == `CTG_CH_CR) || (c == `CTG_CH_LF) ||
				(c == `CTG_CH_SEMI);
		end
	endfunction

	// {ok, care, value} of one map character
	function [2:0] map_bit;
		input [7:0] c;
		begin
			case (fold(c))
				8'h30: map_bit = 3'b110;
				8'h31: map_bit = 3'b111;
				8'h58: map_bit = 3'b100;
				default: map_bit = 3'b000;
			endcase
		end
	endfunction

	function [2:0] kw_group;
		input [31:0] k;
		begin
			case (k)
				`CTG_KW_COND:  kw_group = 3'h1;
				`CTG_KW_DIST:  kw_group = 3'h2;
				`CTG_KW_FIRE:  kw_group = 3'h3;
				`CTG_KW_BMAP:  kw_group = 3'h4;
				`CTG_KW_PULSE: kw_group = 3'h5;
				`CTG_KW_RTIME: kw_group = 3'h6;
				`CTG_KW_IO:    kw_group = 3'h7;
				default:       kw_group = G_NONE;
			endcase
		end
	endfunction

	// ****************************************
	// synchronisers
	// ****************************************
	wire [7:0]  in_s;
	wire [9:0]  rib_s;
	wire        step_s;

	ctg_sync #(.W(8)) u_sync_in
	(
		.clk  (CLOCK),
		.nrst (NRST),
		.d    (GEN_IN),
		.q    (in_s)
	);

	ctg_sync #(.W(10)) u_sync_rib
	(
		.clk  (CLOCK),
		.nrst (NRST),
		.d    ({POS_STEP, CMD_STROBE, CMD_DATA}),
		.q    (rib_s)
	);

	assign step_s = rib_s[9];

	// ****************************************
	// state
	// ****************************************
	reg          strb_d_reg;
	reg          step_d_reg;
	reg  [7:0]   hold_reg;
	reg          hold_v_reg;
	reg  [1:0]   st_reg;
	reg  [31:0]  kw_reg;
	reg  [2:0]   kcnt_reg;
	reg  [2:0]   grp_reg;
	reg  [2:0]   last_grp_reg;
	reg  [1:0]   fld_reg;
	reg  [4:0]   ccnt_reg;
	reg  [3:0]   pmode_reg;
	reg  [3:0]   pa1_reg;
	reg  [3:0]   pa2_reg;
	reg  [7:0]   pinc_reg;
	reg  [7:0]   pinv_reg;
	reg  [15:0]  poutc_reg;
	reg  [15:0]  poutv_reg;
	reg          bad_reg;
	reg          err_reg;
	reg  [1:0]   mode_reg;
	reg  [2:0]   sel_reg;
	reg          lvl_reg;
	reg  [7:0]   inc_reg;
	reg  [7:0]   inv_reg;
	reg  [15:0]  outc_reg;
	reg  [15:0]  outv_reg;
	reg          ext_reg;
	reg  [CW-1:0] cnt_reg;
	wire         cond;

	// ribbon byte wins; a software byte waits in the holding register
	wire         rib_v  = rib_s[8] & ~strb_d_reg;
	wire         byte_v = rib_v | hold_v_reg;
	wire [7:0]   byte_c = rib_v ? rib_s[7:0] : hold_reg;
	wire [7:0]   uc     = fold(byte_c);
	wire [4:0]   need_len = (fld_reg == 2'h0) ? 5'd1 :
		(pmode_reg != 4'h3) ? 5'd1 :
		(fld_reg == 2'h1) ? 5'd8 : 5'd16;
	wire         len_ok = (ccnt_reg == need_len);
	wire [2:0]   mb     = map_bit(byte_c);
	wire         dig    = (byte_c >= 8'h30) && (byte_c <= 8'h39);
	wire [3:0]   dval   = byte_c[3:0];
	wire         cmd_ok = !bad_reg && len_ok && (
		(pmode_reg == 4'h0 && fld_reg == 2'h0) ||
		((pmode_reg == 4'h1 || pmode_reg == 4'h2) && fld_reg == 2'h2 &&
			pa1_reg <= 4'h7 && pa2_reg <= 4'h1) ||
		(pmode_reg == 4'h3 && fld_reg == 2'h2));

	// ****************************************
	// command parser
	// ****************************************
	reg          parse_err;

	always @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			st_reg       <= ST_KW;
			kw_reg       <= 32'h00000000;
			kcnt_reg     <= 3'h0;
			grp_reg      <= G_NONE;
			last_grp_reg <= G_NONE;
			fld_reg      <= 2'h0;
			ccnt_reg     <= 5'h00;
			pmode_reg    <= 4'h0;
			pa1_reg      <= 4'h0;
			pa2_reg      <= 4'h0;
			pinc_reg     <= 8'h00;
			pinv_reg     <= 8'h00;
			poutc_reg    <= 16'h0000;
			poutv_reg    <= 16'h0000;
			bad_reg      <= 1'b0;
			mode_reg     <= `CTG_RST_MODE;
			sel_reg      <= 3'h0;
			lvl_reg      <= 1'b0;
			inc_reg      <= 8'h00;
			inv_reg      <= 8'h00;
			outc_reg     <= 16'h0000;
			outv_reg     <= 16'h0000;
			parse_err    <= 1'b0;
		end
		else
		begin
			parse_err <= 1'b0;
			if (byte_v)
			begin
				case (st_reg)
					ST_KW:
					begin
						if (kcnt_reg != 3'h4)
						begin
							if (is_term(byte_c))
							begin
								kcnt_reg  <= 3'h0;
								parse_err <= (kcnt_reg != 3'h0);
							end
							else if (!(kcnt_reg == 3'h0 && uc == `CTG_CH_SPACE))
							begin
								kw_reg   <= {kw_reg[23:0], uc};
								kcnt_reg <= kcnt_reg + 3'h1;
							end
						end
						else
						begin
							kcnt_reg <= 3'h0;
							grp_reg  <= kw_group(kw_reg);
							fld_reg  <= 2'h0;
							ccnt_reg <= 5'h00;
							bad_reg  <= 1'b0;
							pinc_reg <= 8'h00;
							poutc_reg <= 16'h0000;
							if (kw_group(kw_reg) == G_NONE)
							begin
								parse_err <= 1'b1;
								st_reg    <= is_term(byte_c) ? ST_KW : ST_SKIP;
							end
							else
							begin
								last_grp_reg <= kw_group(kw_reg);
								if (kw_group(kw_reg) == G_COND)
								begin
									// the mode argument is not optional
									if (byte_c == `CTG_CH_COMMA)
										st_reg <= ST_ARGS;
									else
									begin
										parse_err <= 1'b1;
										st_reg    <= is_term(byte_c) ? ST_KW : ST_SKIP;
									end
								end
								else
									st_reg <= is_term(byte_c) ? ST_KW : ST_SKIP;
							end
						end
					end
					ST_ARGS:
					begin
						if (is_term(byte_c))
						begin
							st_reg <= ST_KW;
							if (cmd_ok)
							begin
								mode_reg <= pmode_reg[1:0];
								sel_reg  <= pa1_reg[2:0];
								lvl_reg  <= pa2_reg[0];
								if (pmode_reg == 4'h3)
								begin
									inc_reg  <= pinc_reg;
									inv_reg  <= pinv_reg;
									outc_reg <= poutc_reg;
									outv_reg <= poutv_reg;
								end
							end
							else
								parse_err <= 1'b1;
						end
						else if (byte_c == `CTG_CH_COMMA)
						begin
							if (!len_ok || fld_reg == 2'h2)
								bad_reg <= 1'b1;
							else
								fld_reg <= fld_reg + 2'h1;
							ccnt_reg <= 5'h00;
						end
						else if (byte_c != `CTG_CH_SPACE)
						begin
							if (ccnt_reg != 5'h1f)
								ccnt_reg <= ccnt_reg + 5'h01;
							if (fld_reg == 2'h0)
							begin
								bad_reg   <= bad_reg | ~dig;
								pmode_reg <= dval;
							end
							else if (pmode_reg == 4'h3)
							begin
								bad_reg <= bad_reg | ~mb[2];
								// rightmost character lands on bit 0
								if (fld_reg == 2'h1)
								begin
									pinc_reg <= {pinc_reg[6:0], mb[1]};
									pinv_reg <= {pinv_reg[6:0], mb[0]};
								end
								else
								begin
									poutc_reg <= {poutc_reg[14:0], mb[1]};
									poutv_reg <= {poutv_reg[14:0], mb[0]};
								end
							end
							else
							begin
								bad_reg <= bad_reg | ~dig;
								if (fld_reg == 2'h1)
									pa1_reg <= dval;
								else
									pa2_reg <= dval;
							end
						end
					end
					ST_SKIP:
					begin
						// other groups are recognised but not executed here
						if (is_term(byte_c))
							st_reg <= ST_KW;
					end
					default:
						st_reg <= ST_KW;
				endcase
			end
		end
	end

	// ****************************************
	// condition, outputs and position count
	// ****************************************
	ctg_cond u_cond
	(
		.mode    (mode_reg),
		.sel     (sel_reg),
		.lvl     (lvl_reg),
		.in_care (inc_reg),
		.in_val  (inv_reg),
		.ext     (ext_reg),
		.ins     (in_s),
		.cond    (cond)
	);

	wire [15:0] out_mask = ext_reg ? 16'hffff : 16'h000f;
	wire [15:0] out_next = ((GEN_OUT & ~outc_reg) | (outv_reg & outc_reg))
		& out_mask;

	always @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			TRACK_EN   <= 1'b0;
			GEN_OUT    <= `CTG_RST_OUT;
			cnt_reg    <= {CW{1'b0}};
			step_d_reg <= 1'b0;
		end
		else
		begin
			step_d_reg <= step_s;
			TRACK_EN   <= cond;
			if (mode_reg == 2'h3 && !cond)
				GEN_OUT <= out_next;
			else
				GEN_OUT <= GEN_OUT & out_mask;
			// mode 1 keeps the count, mode 2 clears it on disable
			if (mode_reg == 2'h2 && TRACK_EN && !cond)
				cnt_reg <= {CW{1'b0}};
			else if (TRACK_EN && step_s && !step_d_reg)
				cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************
	// avalon-mm slave
	// ****************************************
	wire req    = AVS_READ | AVS_WRITE;
	wire cmd_wr = AVS_WRITE && (AVS_ADDRESS == `CTG_OFS_CMD);
	// a byte write waits while the holding register is still full
	wire can_go = !(cmd_wr && hold_v_reg);
	wire wr_now = AVS_WRITE && !AVS_WAITREQUEST;

	always @(posedge CLOCK)
	begin
		if (!NRST)
		begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h00000000;
			hold_reg        <= 8'h00;
			hold_v_reg      <= 1'b0;
			strb_d_reg      <= 1'b0;
			ext_reg         <= `CTG_RST_EXT;
			err_reg         <= 1'b0;
		end
		else
		begin
			strb_d_reg <= rib_s[8];
			AVS_WAITREQUEST <= !(req && AVS_WAITREQUEST && can_go);
			if (byte_v && !rib_v)
				hold_v_reg <= 1'b0;
			if (wr_now && cmd_wr)
			begin
				hold_reg   <= AVS_WRITEDATA[7:0];
				hold_v_reg <= 1'b1;
			end
			if (wr_now && AVS_ADDRESS == `CTG_OFS_CTRL)
				ext_reg <= AVS_WRITEDATA[`CTG_CTRL_EXT_BIT];
			// a new error wins over a clear in the same cycle
			if (parse_err)
				err_reg <= 1'b1;
			else if (wr_now && AVS_ADDRESS == `CTG_OFS_CTRL &&
				AVS_WRITEDATA[`CTG_CTRL_ECLR_BIT])
				err_reg <= 1'b0;
			if (AVS_READ && AVS_WAITREQUEST)
			begin
				case (AVS_ADDRESS)
					`CTG_OFS_CTRL:    AVS_READDATA <= {31'h0, ext_reg};
					`CTG_OFS_STATUS:  AVS_READDATA <= {24'h0, hold_v_reg,
						last_grp_reg, err_reg, mode_reg, TRACK_EN};
					`CTG_OFS_INPUTS:  AVS_READDATA <= {24'h0, in_s};
					`CTG_OFS_OUTPUTS: AVS_READDATA <= {16'h0, GEN_OUT};
					`CTG_OFS_INMAP:   AVS_READDATA <= {16'h0, inc_reg, inv_reg};
					`CTG_OFS_OUTMAP:  AVS_READDATA <= {outc_reg, outv_reg};
					`CTG_OFS_SELECT:  AVS_READDATA <= {27'h0, lvl_reg, 1'b0,
						sel_reg};
					`CTG_OFS_POSCNT:  AVS_READDATA <= {{(32-CW){1'b0}}, cnt_reg};
					default:          AVS_READDATA <= 32'h00000000;
				endcase
			end
		end
	end

endmodule // ctg_gate

// >>> bench/ctg_ctl_model.sv
// controller model: sends command text over the ribbon byte port
`timescale 1ns/10ps
module ctg_ctl_model
(
	// clock
	input  wire       clk,
	// ribbon port
	output reg  [7:0] cmd_data,
	output reg        cmd_strobe
);
	initial
	begin
		cmd_data = 8'h00;
		cmd_strobe = 1'h0;
	end

	// data set a clock before the rise and kept four after it; then the
	// inverse goes out so a stale byte can never pass for a fresh one
	task send_line(input string s);
		int i;
		for (i = 0; i < s.len(); i++)
		begin
			@(posedge clk) cmd_data <= s[i];
			@(posedge clk) cmd_strobe <= 1'h1;
			repeat (4) @(posedge clk);
			cmd_strobe <= 1'h0;
			cmd_data <= ~s[i];
			repeat (3) @(posedge clk);
		end
	endtask
endmodule // ctg_ctl_model

// >>> bench/ctg_gate_properties.sv
// port-level assertions for the conditional tracking gate
`timescale 1ns/10ps
`include "ctg_defines.vh"
module ctg_gate_properties
(
	// clock and reset
	input wire        CLOCK,
	input wire        NRST,
	// avalon-mm slave
	input wire [5:0]  AVS_ADDRESS,
	input wire        AVS_READ,
	input wire        AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [31:0] AVS_READDATA,
	input wire        AVS_WAITREQUEST,
	// ribbon, inputs and outputs
	input wire [7:0]  CMD_DATA,
	input wire        CMD_STROBE,
	input wire [7:0]  GEN_IN,
	input wire        POS_STEP,
	input wire [15:0] GEN_OUT,
	input wire        TRACK_EN
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);

	// **********
	// assertions
	// **********
	a_reset_default: assert property (
		$rose(NRST) |-> !TRACK_EN && GEN_OUT == 16'h0 ##1 TRACK_EN)
		else $error("tracking not on after reset");
	a_wait_pulse: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	a_read_answer: assert property (
		AVS_READ && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("read not answered next cycle");
	a_write_bound: assert property (
		AVS_WRITE && AVS_WAITREQUEST |-> ##[1:40] !AVS_WAITREQUEST)
		else $error("write not answered");
	a_idle_quiet: assert property (
		!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
		else $error("answer without request");
	a_unmapped_zero: assert property (
		AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS > `CTG_OFS_POSCNT
		|-> AVS_READDATA == 32'h0) else $error("unmapped read not zero");
	a_rdata_stands: assert property (
		$changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
		else $error("read data moved outside a read");
	a_out_gated: assert property (
		$changed(GEN_OUT) |-> !TRACK_EN || !$past(TRACK_EN))
		else $error("outputs moved while tracking");
endmodule // ctg_gate_properties

bind ctg_gate ctg_gate_properties i_props (.CLOCK, .NRST, .AVS_ADDRESS,
	.AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
	.AVS_WAITREQUEST, .CMD_DATA, .CMD_STROBE, .GEN_IN, .POS_STEP,
	.GEN_OUT, .TRACK_EN);

// >>> bench/ctg_gate_test.sv
// self-checking bench for the conditional tracking gate
`timescale 1ns/10ps
`include "ctg_defines.vh"
module ctg_gate_test;
	// **********
	// signals
	// **********
	reg         clk = 1'h0;
	reg         nrst = 1'h0;
	reg  [5:0]  addr = 6'h00;
	reg         rd = 1'h0;
	reg         wr = 1'h0;
	reg  [31:0] wdata = 32'h0;
	wire [31:0] rdata;
	wire        wreq;
	wire [7:0]  cmd_d;
	wire        cmd_s;
	reg  [7:0]  gin = 8'h25;
	reg         step = 1'h0;
	wire [15:0] gout;
	wire        trk;
	reg  [31:0] q;
	int         n_errors = 0;
	int         num_checks = 0;
	int         cyc = 0;
	int         i;
	string      grp [7];
	string      kc_lo;
	string      kc_up;

	always #50 clk = ~clk;

	ctg_gate i_dut (.CLOCK(clk), .NRST(nrst), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .CMD_DATA(cmd_d),
		.CMD_STROBE(cmd_s), .GEN_IN(gin), .POS_STEP(step),
		.GEN_OUT(gout), .TRACK_EN(trk));
	ctg_ctl_model i_ctl (.clk(clk), .cmd_data(cmd_d), .cmd_strobe(cmd_s));

	// **********
	// tasks
	// **********
	// command words built from the shared codes; low picks letters to fold
	function string kw(input logic [31:0] k, input logic [31:0] low);
		return $sformatf("%s", k | low);
	endfunction

	task give_verdict;
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		do @(posedge clk); while (wreq !== 1'h0);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask

	task rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(nm, e, q);
	endtask

	// inputs and strobes cross two sync stages, so every change gets slack
	task settle;
		repeat (8) @(posedge clk);
	endtask

	task pulse;
		@(posedge clk) step <= 1'h1;
		repeat (3) @(posedge clk);
		step <= 1'h0;
		repeat (3) @(posedge clk);
	endtask

	task setin(input logic [7:0] v);
		@(posedge clk) gin <= v;
		settle();
	endtask

	task line(input string s);
		i_ctl.send_line(s);
		settle();
	endtask

	task cmdreg(input string s);
		int j;
		for (j = 0; j < s.len(); j++)
			bus(1'h1, `CTG_OFS_CMD, {24'h0, s[j]});
		settle();
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	// **********
	// sequence
	// **********
	initial
	begin
		kc_lo = kw(`CTG_KW_COND, 32'h20202020);
		kc_up = kw(`CTG_KW_COND, 32'h00000000);
		grp[0] = {kc_lo, ",0;"};
		grp[1] = {kw(`CTG_KW_DIST, 32'h00000000), ",0,100;"};
		grp[2] = {kw(`CTG_KW_FIRE, 32'h20202000), ",3,x;"};
		grp[3] = {kw(`CTG_KW_BMAP, 32'h00202000), ";"};
		grp[4] = {kw(`CTG_KW_PULSE, 32'h20202020), ",4,1000;"};
		grp[5] = {kw(`CTG_KW_RTIME, 32'h20000000), ";"};
		grp[6] = {kw(`CTG_KW_IO, 32'h20202000), ";"};
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		settle();
		chk("track", 32'h1, trk);
		chk("outs", 32'h0, gout);
		rchk("status", `CTG_OFS_STATUS, 32'h1);
		bus(1'h1, `CTG_OFS_CTRL, 32'h1);
		rchk("ctrl", `CTG_OFS_CTRL, 32'h1);
		for (i = 0; i < 7; i++)
		begin
			line(grp[i]);
			rchk("group", `CTG_OFS_STATUS, 32'((i + 1) * 16 + 1));
		end
		line({kc_up, ",1,5,1;"});
		chk("track", 32'h1, trk);
		repeat (3) pulse();
		setin(8'h05);
		chk("track", 32'h0, trk);
		pulse();
		rchk("count", `CTG_OFS_POSCNT, 32'h3);
		// mode 2 counts like mode 1 but clears when tracking drops
		setin(8'h25);
		line({kc_lo, ",2,5,1;"});
		pulse();
		rchk("count", `CTG_OFS_POSCNT, 32'h4);
		setin(8'h05);
		rchk("count", `CTG_OFS_POSCNT, 32'h0);
		line({kc_lo, ",4;"});
		line({kc_lo, ",1,8,1;"});
		rchk("status", `CTG_OFS_STATUS, 32'h1c);
		rchk("select", `CTG_OFS_SELECT, 32'h15);
		bus(1'h1, `CTG_OFS_CTRL, 32'h3);
		rchk("status", `CTG_OFS_STATUS, 32'h14);
		setin(8'h25);
		line({kc_lo, ",3,xx1x0101,xxxx11000011xxxx\r"});
		chk("track", 32'h1, trk);
		rchk("inmap", `CTG_OFS_INMAP, 32'h2f25);
		rchk("outmap", `CTG_OFS_OUTMAP, 32'h0ff00c30);
		setin(8'ha5);
		chk("track", 32'h1, trk);
		setin(8'h24);
		chk("track", 32'h0, trk);
		chk("outs", 32'h0c30, gout);
		rchk("inputs", `CTG_OFS_INPUTS, 32'h24);
		rchk("outputs", `CTG_OFS_OUTPUTS, 32'h0c30);
		line({kc_up, ",3,XX1X0101,xxxxxxxx0000xxxx\n"});
		chk("outs", 32'h0c00, gout);
		bus(1'h1, `CTG_OFS_CTRL, 32'h0);
		settle();
		chk("outs", 32'h0, gout);
		setin(8'h05);
		chk("track", 32'h1, trk);
		cmdreg({kc_lo, ",0;"});
		rchk("status", `CTG_OFS_STATUS, 32'h11);
		rchk("unmapped", 6'h3c, 32'h0);
		pulse();
		rchk("count", `CTG_OFS_POSCNT, 32'h1);
		// a reset in mid-run must bring back the unconditional default
		nrst <= 1'h0;
		repeat (4) @(posedge clk);
		nrst <= 1'h1;
		settle();
		chk("track", 32'h1, trk);
		rchk("status", `CTG_OFS_STATUS, 32'h1);
		rchk("count", `CTG_OFS_POSCNT, 32'h0);
		give_verdict();
	end
endmodule // ctg_gate_test
